// ### core/cmm_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - reference-hold 1 keeps reference on until a config write clears it; 0 turns it off after conversion
// - read-only config bit mirrors discharge-timer enable pin; writes ignored
// - rate option bit set selects the alternate rate set for the rate field
// - under level (thr+1)*16, over level thr*16 in 100uV units; thresholds reset zero
// - timeout code 0 disables, 1..f set 0.5..120 min; read returns band left
// - analog and digital supply results are 16-bit codes in 100uV steps
// - while not busy, cell over flag set when cell exceeds over level, cleared otherwise
// - while not busy, cell under flag set when cell below under level, cleared otherwise
// - thermal flag set on shutdown, cleared by reading status group b
// - after transfer leading nibbles rewritten: i2c takes the aux_rx_trail nibble, spi returns 0111
// - aux data bytes sent out, then replaced by bytes received from slave
// - thresholds and results compared as unsigned values
// - written data held until chip select rises, then latched
// - chained read: this device shifts out its group, then passes farther data
// - frame: two command bytes, two check bytes, then six data plus two check
// - poll drives data output low while busy, updated every enabled core clock
// - data output goes high once conversions complete; chip select rise ends poll
// - write-config command code is 0x001
// - convert command bits 10:9=01, 6:5=11 carry rate and permit fields
module cmm_monitor
  import cmm_pkg::*;
#(
  parameter int unsigned HALF_MIN_CYC = cmm_pkg::CMM_HALF_MIN_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic chip_select_n,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  input wire logic chain_sdi,
  input wire logic timer_pin,
  input wire logic thermal_event,
  input wire logic selftest_fail,
  input wire logic conv_busy,
  input wire logic [15:0] sum_cells,
  input wire logic [15:0] die_temp,
  input wire logic [15:0] analog_supply,
  input wire logic [15:0] digital_supply,
  input wire logic [191:0] cell_volts,
  input wire logic aux_done,
  input wire logic [23:0] aux_rx,
  input wire logic [11:0] aux_rx_trail,
  output logic reference_on,
  output logic conv_start,
  output logic [1:0] rate_select_field,
  output logic rate_set_option,
  output logic discharge_permit,
  output logic [11:0] cell_discharge_switch,
  output logic aux_start,
  output logic [47:0] aux_tx
);
  import cmm_pkg::*;
  logic cs_act_s, cs_n_s, sck_s, sdi_s, chain_s, tpin_s, therm_s, mux_s, busy_s, auxd_s;
  logic sck_d_r, cs_d_r;
  logic sck_rise, sck_fall, cs_rise, cs_fall;
  cmm_state_e st_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic [3:0] byte_r;
  logic [10:0] cmd_r;
  logic [47:0] wbuf_r;
  logic [47:0] rbuf_r;
  logic [7:0] cfg0_r;
  logic [11:0] uth_r, oth_r;
  logic [3:0] discharge_timeout_code_r;
  logic [47:0] comm_r;
  logic thermal_r, read_b_r, pending_cfg_r, pending_comm_r;
  logic [23:0] flags_r;
  logic [3:0] band;
  logic tmo_load_r;
  logic [7:0] rx_byte;
  logic conv_cmd;

  cmm_sync #(.W(3)) u_sync_link (
    .clk(core_clk), .rst_b(rst_b), .en(clk_en),
    .d({~chip_select_n, sck, sdi}), .q({cs_act_s, sck_s, sdi_s})
  );
  // select is synchronised inverted so that its reset value matches the idle pin
  assign cs_n_s = ~cs_act_s;
  cmm_sync #(.W(6)) u_sync_misc (
    .clk(core_clk), .rst_b(rst_b), .en(clk_en),
    .d({chain_sdi, timer_pin, thermal_event, selftest_fail, conv_busy, aux_done}),
    .q({chain_s, tpin_s, therm_s, mux_s, busy_s, auxd_s})
  );
  cmm_dctimer #(.HALF_MIN_CYC(HALF_MIN_CYC)) u_timer (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
    .load(tmo_load_r), .code(discharge_timeout_code_r), .band(band)
  );

  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;
  assign cs_rise = cs_n_s & ~cs_d_r;
  assign cs_fall = ~cs_n_s & cs_d_r;
  assign rx_byte = {sh_r[6:0], sdi_s};
  assign conv_cmd = (cmd_r[10:9] == CMM_CONV_TOP) && (cmd_r[6:5] == 2'b11) && !cmd_r[3];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else if (clk_en) begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_n_s;
    end
  end

  // frame sequencer: command bytes, then data groups
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= CMM_IDLE;
      bit_r <= 3'd0;
      byte_r <= 4'd0;
      sh_r <= 8'h00;
      cmd_r <= 11'h000;
      wbuf_r <= '0;
    end else if (clk_en) begin
      if (cs_n_s) begin
        st_r <= CMM_IDLE;
      end else if (cs_fall) begin
        st_r <= CMM_CMD;
        bit_r <= 3'd0;
        byte_r <= 4'd0;
      end else if (sck_rise) begin
        sh_r <= rx_byte;
        bit_r <= bit_r + 3'd1;
        if (bit_r == 3'd7) begin
          case (st_r)
            CMM_CMD: begin
              if (byte_r == 4'd0) cmd_r[10:8] <= rx_byte[2:0];
              if (byte_r == 4'd1) cmd_r[7:0] <= rx_byte;
              if (byte_r == CMM_CMD_BYTES - 4'd1) begin
                byte_r <= 4'd0;
                st_r <= (cmd_r == CMM_CMD_CONVERSION_POLL_CMD || conv_cmd) ? CMM_POLL : CMM_DATA;
              end else begin
                byte_r <= byte_r + 4'd1;
              end
            end
            CMM_DATA: begin
              // last group received is this device's, earlier ones are shifted out and dropped
              if (byte_r < CMM_DATA_BYTES) wbuf_r <= {wbuf_r[39:0], rx_byte};
              byte_r <= (byte_r == CMM_GROUP_BYTES - 4'd1) ? 4'd0 : byte_r + 4'd1;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // read shift path: own group first, then bits from the farther device
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rbuf_r <= '0;
      sdo <= 1'b1;
    end else if (clk_en) begin
      if (st_r == CMM_POLL) begin
        sdo <= ~busy_s;
      end else if (st_r == CMM_CMD && byte_r == 4'd3 && bit_r == 3'd7 && sck_rise) begin
        case (cmd_r)
          CMM_CMD_RDCFG: rbuf_r <= {cfg0_r[7:3], cfg0_r[2], tpin_s, cfg0_r[0],
                                    uth_r[7:0], oth_r[3:0], uth_r[11:8], oth_r[11:4],
                                    cell_discharge_switch[7:0], band,
                                    cell_discharge_switch[11:8]};
          CMM_CMD_RDSTA: rbuf_r <= {sum_cells[7:0], sum_cells[15:8], die_temp[7:0],
                                    die_temp[15:8], analog_supply[7:0],
                                    analog_supply[15:8]};
          CMM_CMD_RDSTB: rbuf_r <= {digital_supply[7:0], digital_supply[15:8],
                                    flags_r[7:0], flags_r[15:8], flags_r[23:16],
                                    CMM_REVISION, 2'b00, mux_s, thermal_r};
          CMM_CMD_RDCOMM: rbuf_r <= comm_r;
          default: rbuf_r <= '1;
        endcase
      end else if (st_r == CMM_DATA && sck_fall) begin
        sdo <= rbuf_r[47];
        rbuf_r <= {rbuf_r[46:0], chain_s};
      end else if (st_r == CMM_IDLE) begin
        sdo <= 1'b1;
      end
    end
  end

  // latch on chip-select rise
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_cfg_r <= 1'b0;
      pending_comm_r <= 1'b0;
      read_b_r <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        pending_cfg_r <= 1'b0;
        pending_comm_r <= 1'b0;
        read_b_r <= 1'b0;
      end else if (st_r == CMM_DATA && byte_r == CMM_DATA_BYTES && bit_r == 3'd0) begin
        pending_cfg_r <= (cmd_r == CMM_CMD_WRITE_CONFIG_CMD);
        pending_comm_r <= (cmd_r == CMM_CMD_WRCOMM);
        read_b_r <= (cmd_r == CMM_CMD_RDSTB);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg0_r <= CMM_CFG_RESET;
      uth_r <= CMM_THRESH_RESET;
      oth_r <= CMM_THRESH_RESET;
      discharge_timeout_code_r <= 4'h0;
      cell_discharge_switch <= 12'h000;
      tmo_load_r <= 1'b0;
    end else if (clk_en) begin
      tmo_load_r <= 1'b0;
      if (cs_rise && pending_cfg_r) begin
        cfg0_r <= wbuf_r[47:40] & ~(8'h01 << CMM_TIMER_PIN_BIT);
        uth_r <= {wbuf_r[27:24], wbuf_r[39:32]};
        oth_r <= {wbuf_r[23:16], wbuf_r[31:28]};
        cell_discharge_switch <= {wbuf_r[3:0], wbuf_r[15:8]};
        discharge_timeout_code_r <= wbuf_r[7:4];
        tmo_load_r <= 1'b1;
      end
    end
  end

  // aux communication group; i2c codes come back from the master engine
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      comm_r <= {6{8'h00}};
      aux_start <= 1'b0;
    end else if (clk_en) begin
      aux_start <= cs_rise && st_r != CMM_IDLE && cmd_r == CMM_CMD_STCOMM;
      if (cs_rise && pending_comm_r) begin
        comm_r <= wbuf_r;
      end else if (auxd_s) begin
        for (int i = 0; i < 3; i++) begin
          comm_r[47-16*i -: 4] <= comm_r[47-16*i] ? CMM_SPI_READ_LEAD
                                                  : aux_rx_trail[11-4*i -: 4];
          comm_r[43-16*i -: 8] <= aux_rx[23-8*i -: 8];
          comm_r[35-16*i -: 4] <= comm_r[47-16*i] ? CMM_SPI_READ_TRAIL
                                                  : aux_rx_trail[11-4*i -: 4];
        end
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_tx <= '0;
    end else if (clk_en) begin
      aux_tx <= comm_r;
    end
  end

  // thermal flag: a new event beats a clear-on-read
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      thermal_r <= 1'b0;
    end else if (clk_en) begin
      if (therm_s) begin
        thermal_r <= 1'b1;
      end else if (cs_rise && read_b_r) begin
        thermal_r <= 1'b0;
      end
    end
  end

  // cell comparisons against scaled thresholds, unsigned
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= '0;
    end else if (clk_en && !busy_s) begin
      for (int c = 0; c < 12; c++) begin
        flags_r[2*c+1] <= {1'b0, cell_volts[16*c +: 16]} > ({5'd0, oth_r} << CMM_THRESH_SCALE_SH);
        flags_r[2*c] <= {1'b0, cell_volts[16*c +: 16]} <
                        (({5'd0, uth_r} + 17'd1) << CMM_THRESH_SCALE_SH);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_start <= 1'b0;
      rate_select_field <= 2'b00;
      discharge_permit <= 1'b0;
      rate_set_option <= 1'b0;
      reference_on <= 1'b0;
    end else if (clk_en) begin
      conv_start <= cs_rise && st_r == CMM_POLL && conv_cmd;
      if (cs_rise && st_r == CMM_POLL && conv_cmd) begin
        rate_select_field <= cmd_r[8:7];
        discharge_permit <= cmd_r[4];
      end
      rate_set_option <= cfg0_r[CMM_RATE_OPT_BIT];
      reference_on <= cfg0_r[CMM_REF_HOLD_BIT] | busy_s;
    end
  end

  a_thermal_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && therm_s |=> thermal_r) else $error("thermal flag not set");
  a_ref_hold_on: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && cfg0_r[CMM_REF_HOLD_BIT] |=> reference_on) else $error("ref dropped");
  a_poll_busy_low: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && st_r == CMM_POLL && busy_s |=> !sdo) else $error("poll sdo high while busy");
  a_poll_done_high: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && st_r == CMM_POLL && !busy_s |=> sdo) else $error("poll sdo low when done");
  a_cfg_latch_cs: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(clk_en && cs_rise && pending_cfg_r) |=> $stable(uth_r)) else $error("cfg moved early");
  a_pin_bit_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    !cfg0_r[CMM_TIMER_PIN_BIT]) else $error("pin bit stored");
  a_rate_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en ##1 clk_en |-> rate_set_option == $past(cfg0_r[CMM_RATE_OPT_BIT]))
    else $error("rate option stale");
  a_thermal_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && cs_rise && read_b_r && !therm_s |=> !thermal_r) else $error("no clear");
endmodule
`default_nettype wire

// ### shared/cmm_pkg.sv
package cmm_pkg;
  localparam int unsigned CMM_CORE_HZ = 10_000_000;
  // command codes (11 bits)
  localparam logic [10:0] CMM_CMD_WRITE_CONFIG_CMD = 11'h001;
  localparam logic [10:0] CMM_CMD_RDCFG = 11'h002;
  localparam logic [10:0] CMM_CMD_RDSTA = 11'h010;
  localparam logic [10:0] CMM_CMD_RDSTB = 11'h012;
  localparam logic [10:0] CMM_CMD_CLEAR_CELL_RESULTS_CMD = 11'h711;
  localparam logic [10:0] CMM_CMD_CONVERSION_POLL_CMD = 11'h714;
  localparam logic [10:0] CMM_CMD_WRCOMM = 11'h721;
  localparam logic [10:0] CMM_CMD_RDCOMM = 11'h722;
  localparam logic [10:0] CMM_CMD_STCOMM = 11'h723;
  // convert command: bits 10:9 = 01, bits 6:5 = 11, bit 3 = 0
  localparam logic [1:0] CMM_CONV_TOP = 2'h1;
  // frame layout in bytes
  localparam logic [3:0] CMM_CMD_BYTES = 4'h4;
  localparam logic [3:0] CMM_DATA_BYTES = 4'h6;
  localparam logic [3:0] CMM_GROUP_BYTES = 4'h8;
  // config byte 0 fields
  localparam int CMM_RATE_OPT_BIT = 0;
  localparam int CMM_TIMER_PIN_BIT = 1;
  localparam int CMM_REF_HOLD_BIT = 2;
  // status b byte 5 fields
  localparam int CMM_THERMAL_BIT = 0;
  localparam int CMM_SELFTEST_BIT = 1;
  localparam logic [3:0] CMM_REVISION = 4'h1; // arbitrary value
  localparam logic [7:0] CMM_CFG_RESET = 8'h00;
  localparam logic [11:0] CMM_THRESH_RESET = 12'h000;
  localparam logic [3:0] CMM_SPI_READ_LEAD = 4'h7;
  localparam logic [3:0] CMM_SPI_READ_TRAIL = 4'hf;
  localparam logic [3:0] CMM_I2C_START = 4'h6;
  localparam logic [3:0] CMM_I2C_STOP = 4'h1;
  localparam logic [3:0] CMM_I2C_BLANK = 4'h0;
  localparam logic [3:0] CMM_I2C_IDLE = 4'h7;
  localparam logic [3:0] CMM_TRAIL_NACK_STOP = 4'h9;
  localparam logic [3:0] CMM_TRAIL_MACK = 4'h0;
  localparam logic [3:0] CMM_TRAIL_SACK = 4'h7;
  localparam logic [3:0] CMM_TRAIL_SNACK = 4'hf;
  localparam logic [3:0] CMM_TRAIL_SNACK_STOP = 4'h1;
  // threshold scaling: level code = threshold * 16
  localparam int CMM_THRESH_SCALE_SH = 4;
  // discharge timeout minute table, in half minutes
  localparam int unsigned CMM_HALF_MIN_S = 30;
  localparam int unsigned CMM_HALF_MIN_CYC = CMM_HALF_MIN_S * CMM_CORE_HZ;
  typedef enum logic [1:0] {CMM_IDLE, CMM_CMD, CMM_DATA, CMM_POLL} cmm_state_e;

  function automatic logic [7:0] cmm_tmo_halves(input logic [3:0] code);
    logic [7:0] t [16];
    t = '{8'd0, 8'd1, 8'd2, 8'd4, 8'd6, 8'd8, 8'd10, 8'd20, 8'd30, 8'd40, 8'd60,
          8'd80, 8'd120, 8'd150, 8'd180, 8'd240};
    return t[code];
  endfunction
endpackage

// ### core/cmm_sync.sv
`timescale 1ns/100ps
`default_nettype none
module cmm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      q <= '0;
    end else if (en) begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule
`default_nettype wire

// ### core/cmm_dctimer.sv
`timescale 1ns/100ps
`default_nettype none
module cmm_dctimer
  import cmm_pkg::*;
#(
  parameter int unsigned HALF_MIN_CYC = CMM_HALF_MIN_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [3:0] code,
  output logic [3:0] band
);
  import cmm_pkg::*;
  logic [31:0] tick_r;
  logic [7:0] left_r;
  logic [3:0] band_nxt;
  // remaining half minutes, counted down
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_r <= '0;
      left_r <= '0;
    end else if (clk_en) begin
      if (load) begin
        left_r <= cmm_tmo_halves(code);
        tick_r <= '0;
      end else if (left_r != 8'd0) begin
        if (tick_r >= HALF_MIN_CYC - 1) begin
          tick_r <= '0;
          left_r <= left_r - 8'd1;
        end else begin
          tick_r <= tick_r + 32'd1;
        end
      end
    end
  end
  // read back the band holding the time left
  always_comb begin
    band_nxt = 4'h0;
    for (int i = 1; i < 16; i++) begin
      if (left_r > cmm_tmo_halves(4'(i - 1)) && left_r <= cmm_tmo_halves(4'(i))) begin
        band_nxt = 4'(i);
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      band <= 4'h0;
    end else if (clk_en) begin
      band <= band_nxt;
    end
  end
endmodule
`default_nettype wire

// ### testbench/cmm_host.sv
`timescale 1ns/100ps
`default_nettype none
module cmm_host #(
  parameter int unsigned WAKE_CYC = 20
) (
  input wire logic core_clk,
  output logic chip_select_n,
  output logic sck,
  output logic sdi,
  input wire logic sdo
);
  logic [7:0] tx [16];
  logic [7:0] rx [16];
  logic [7:0] rb;

  initial begin
    chip_select_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b1;
  end

  // msb first, sck low then high for 4 core clocks each; sdo taken just before the next fall
  task automatic xbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      sdi <= b[i];
      repeat (4) @(posedge core_clk);
      sck <= 1'b1;
      repeat (4) @(posedge core_clk);
      rb[i] = sdo;
    end
  endtask

  task automatic wake(input int devs, input logic again);
    for (int p = 0; p <= int'(again); p++) begin
      @(posedge core_clk);
      chip_select_n <= 1'b0;
      xbyte(8'hff);
      sck <= 1'b0;
      repeat (4) @(posedge core_clk);
      chip_select_n <= 1'b1;
      repeat (devs * WAKE_CYC) @(posedge core_clk);
    end
  endtask

  task automatic frame(input logic [10:0] cmd, input logic [15:0] ck, input int n);
    @(posedge core_clk);
    chip_select_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    xbyte({5'h00, cmd[10:8]});
    xbyte(cmd[7:0]);
    xbyte(ck[15:8]);
    xbyte(ck[7:0]);
    for (int k = 0; k < n; k++) begin
      xbyte(tx[k]);
      rx[k] = rb;
    end
    sck <= 1'b0;
    repeat (4) @(posedge core_clk);
    chip_select_n <= 1'b1;
    sdi <= ~sdi;
    repeat (8) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ### testbench/cmm_monitor_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cmm_monitor_tb;
  import cmm_pkg::*;
  logic core_clk, rst_b, clk_en, chip_select_n, sck, sdi, sdo, chain_sdi, timer_pin;
  logic thermal_event, selftest_fail, conv_busy, aux_done, reference_on, conv_start;
  logic rate_set_option, discharge_permit, aux_start;
  logic [1:0] rate_select_field;
  logic [11:0] cell_discharge_switch, aux_rx_trail;
  logic [15:0] sum_cells, die_temp, analog_supply, digital_supply;
  logic [191:0] cell_volts;
  logic [23:0] aux_rx;
  logic [47:0] aux_tx;
  int err_count, n_checks, conv_n, aux_n;

  cmm_monitor #(.HALF_MIN_CYC(20)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .chip_select_n(chip_select_n),
    .sck(sck), .sdi(sdi), .sdo(sdo), .chain_sdi(chain_sdi), .timer_pin(timer_pin),
    .thermal_event(thermal_event), .selftest_fail(selftest_fail), .conv_busy(conv_busy),
    .sum_cells(sum_cells), .die_temp(die_temp), .analog_supply(analog_supply),
    .digital_supply(digital_supply), .cell_volts(cell_volts), .aux_done(aux_done),
    .aux_rx(aux_rx), .aux_rx_trail(aux_rx_trail), .reference_on(reference_on),
    .conv_start(conv_start), .rate_select_field(rate_select_field),
    .rate_set_option(rate_set_option), .discharge_permit(discharge_permit),
    .cell_discharge_switch(cell_discharge_switch), .aux_start(aux_start), .aux_tx(aux_tx));

  cmm_host host (.core_clk(core_clk), .chip_select_n(chip_select_n), .sck(sck), .sdi(sdi),
    .sdo(sdo));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (conv_start === 1'b1) conv_n++;
    if (aux_start === 1'b1) aux_n++;
  end

  task automatic chk_b(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_p(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // byte k of a six byte group expected at e[8k+:8]; m0 masks byte 0
  task automatic cmp6(input string nm, input logic [47:0] e, input logic [7:0] m0);
    for (int k = 0; k < 6; k++) begin
      chk_b(nm, e[8*k+:8], host.rx[k] & ((k == 0) ? m0 : 8'hff));
    end
  endtask

  task automatic load(input logic [7:0] b [8]);
    for (int k = 0; k < 8; k++) host.tx[k] = b[k];
  endtask

  task automatic rd(input logic [10:0] c);
    load('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    host.frame(c, 16'h0000, 8);
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    close_out();
  end

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    chain_sdi = 1'b0;
    timer_pin = 1'b0;
    thermal_event = 1'b0;
    selftest_fail = 1'b1;
    conv_busy = 1'b0;
    aux_done = 1'b0;
    aux_rx = 24'h55aacc;
    aux_rx_trail = 12'hfff;
    sum_cells = 16'h1234;
    die_temp = 16'h5678;
    analog_supply = 16'h9abc;
    digital_supply = 16'hdef0;
    cell_volts = {16'hffff, {7{16'h1800}}, 16'h1010, 16'h100f, 16'h2000, 16'h2001};
    for (int k = 8; k < 16; k++) host.tx[k] = 8'h00;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk_p("sdo idle", 48'h1, 48'(sdo));
    chk_p("out reset", 48'h0, 48'({reference_on, rate_set_option, cell_discharge_switch}));
    chk_p("comm reset", 48'h0, aux_tx);
    host.wake(3, 1'b1);
    rd(CMM_CMD_RDCFG);
    cmp6("cfg reset", 48'h0, 8'h07);
    load('{8'h07, 8'h00, 8'h01, 8'h20, 8'h53, 8'hfc, 8'h00, 8'h00});
    host.frame(CMM_CMD_WRITE_CONFIG_CMD, 16'h3d6e, 3);
    chk_p("short write", 48'h0, 48'(rate_set_option));
    for (int k = 0; k < 8; k++) host.tx[k + 8] = host.tx[k];
    load('{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00});
    fork
      host.frame(CMM_CMD_WRITE_CONFIG_CMD, 16'h3d6e, 16);
      begin
        repeat (700) @(posedge core_clk);
        chk_p("before latch", 48'h0, 48'({reference_on, rate_set_option}));
      end
    join
    chk_p("latched", 48'h3c53, 48'({reference_on, rate_set_option, cell_discharge_switch}));
    rd(CMM_CMD_RDCFG);
    cmp6("cfg", 48'hfc5320010005, 8'h07);
    timer_pin <= 1'b1;
    rd(CMM_CMD_RDCFG);
    chk_b("pin level", 8'h07, host.rx[0] & 8'h07);
    rd(CMM_CMD_RDSTA);
    cmp6("status a", {analog_supply, die_temp, sum_cells}, 8'hff);
    thermal_event <= 1'b1;
    @(posedge core_clk);
    thermal_event <= 1'b0;
    rd(CMM_CMD_RDSTB);
    cmp6("status b", {CMM_REVISION, 4'h3, 8'h80, 8'h00, 8'h12, digital_supply}, 8'hff);
    rd(CMM_CMD_RDSTB);
    chk_b("thermal clear", {CMM_REVISION, 4'h2}, host.rx[5]);
    rd(11'h0ff);
    chk_b("unknown cmd", 8'hff, host.rx[0]);
    load('{8'h85, 8'h50, 8'h8a, 8'ha0, 8'h8c, 8'hc9, 8'h00, 8'h00});
    host.frame(CMM_CMD_WRCOMM, 16'h24b2, 8);
    chk_p("comm out", 48'h85508aa08cc9, aux_tx);
    rd(CMM_CMD_RDCOMM);
    cmp6("comm back", 48'hc98ca08a5085, 8'hff);
    host.frame(CMM_CMD_STCOMM, 16'hb9e4, 9);
    chk_p("aux start", 48'h1, 48'(aux_n));
    aux_done <= 1'b1;
    @(posedge core_clk);
    aux_done <= 1'b0;
    rd(CMM_CMD_RDCOMM);
    cmp6("comm rx", 48'hcf7caf7a5f75, 8'hff);
    for (int m = 1; m < 4; m++) begin
      host.frame(11'h260 | (11'(m) << 7) | (11'(~m & 1) << 4), 16'haf42, 0);
      chk_p("convert", 48'({2'(m), ~m[0], 8'(m)}), 48'({rate_select_field, discharge_permit, 8'(conv_n)}));
    end
    conv_busy <= 1'b1;
    fork
      host.frame(CMM_CMD_CONVERSION_POLL_CMD, 16'h1c48, 3);
      begin
        repeat (360) @(posedge core_clk);
        conv_busy <= 1'b0;
      end
    join
    chk_b("poll busy", 8'h00, host.rx[0]);
    chk_b("poll done", 8'hff, host.rx[2]);
    rd(CMM_CMD_RDCFG);
    chk_b("timeout band", 8'h00, host.rx[5] & 8'hf0);
    close_out();
  end
endmodule
`default_nettype wire
